//--- design/dcc_channel.sv
`timescale 1ns/1ns
module dcc_channel
    import dcc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] con,
    input  wire logic [7:0]  trig_sel,
    input  wire logic [31:0] sta_a,
    input  wire logic [31:0] sta_b,
    input  wire logic [13:0] count,
    input  wire logic        cfg_wr,
    input  wire logic        force_req,
    input  wire logic [255:0] irq_src,
    input  wire logic        grant,
    input  wire logic        done,
    output logic             pending,
    output logic [31:0]      mem_addr,
    output logic             collide,
    output logic             use_b,
    output logic             force_done,
    output logic             irq_pulse
);
    logic        pend_q;
    logic        use_b_q;
    logic [13:0] idx_q;
    logic        irq_q;
    logic        fdone_q;
    logic        trig;
    logic        last;
    logic        half;
    logic [31:0] base;
    logic [31:0] step;
    logic        fin;

    assign fin      = done & grant;
    // Force counts once: masked while pending and in the cycle after it ends
    assign trig     = con[CON_ON] & (irq_src[trig_sel] | (force_req & ~pend_q & ~fdone_q));
    assign last     = (idx_q == count);
    assign half     = (idx_q == (count >> 1));
    assign base     = use_b_q ? sta_b : sta_a;
    assign step     = con[CON_SIZE] ? 32'h1 : 32'h2;
    assign pending  = pend_q;
    assign use_b    = use_b_q;
    assign irq_pulse  = irq_q;
    assign force_done = fdone_q;
    assign collide  = trig & pend_q & ~fin;
    assign mem_addr = (con[CON_AM_LO +: 2] == AM_POSTINC)
                    ? base + step * {18'h0, idx_q} : base;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
        end else if (!con[CON_ON]) begin
            pend_q <= 1'b0;
        end else if (trig) begin
            pend_q <= 1'b1;
        end else if (fin) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_q   <= 14'h0;
            use_b_q <= 1'b0;
            irq_q   <= 1'b0;
            fdone_q <= 1'b0;
        end else begin
            irq_q   <= 1'b0;
            fdone_q <= 1'b0;
            if (cfg_wr || !con[CON_ON]) begin
                idx_q   <= 14'h0;
                use_b_q <= cfg_wr ? use_b_q : 1'b0;
            end else if (fin) begin
                fdone_q <= force_req;
                irq_q   <= con[CON_HALF] ? half : last;
                if (last) begin
                    idx_q <= 14'h0;
                    if (con[CON_MD_LO + MD_PP]) begin
                        use_b_q <= ~use_b_q;
                    end
                end else begin
                    idx_q <= idx_q + 14'h1;
                end
            end
        end
    end
endmodule

//--- design/dcc_pkg.sv
package dcc_pkg;
    localparam int unsigned NUM_CH       = 4;
    localparam int unsigned ADDR_W       = 8;
    // Per-channel register block: 0x20 bytes each, channel n at n*0x20
    localparam logic [7:0] CH_STRIDE     = 8'h20;
    localparam logic [4:0] OFF_CON       = 5'h00;
    localparam logic [4:0] OFF_REQ       = 5'h04;
    localparam logic [4:0] OFF_STAH      = 5'h08;
    localparam logic [4:0] OFF_STAL      = 5'h0c;
    localparam logic [4:0] OFF_STBH      = 5'h10;
    localparam logic [4:0] OFF_STBL      = 5'h14;
    localparam logic [4:0] OFF_PAD       = 5'h18;
    localparam logic [4:0] OFF_CNT       = 5'h1c;
    // Shared status block
    localparam logic [7:0] OFF_PWC       = 8'h80;
    localparam logic [7:0] OFF_RQC       = 8'h84;
    localparam logic [7:0] OFF_PPS       = 8'h88;
    localparam logic [7:0] OFF_LCA       = 8'h8c;
    localparam logic [7:0] OFF_LADRH     = 8'h90;
    localparam logic [7:0] OFF_LADRL     = 8'h94;
    // Control field positions
    localparam int unsigned CON_ON       = 15;
    localparam int unsigned CON_SIZE     = 14;
    localparam int unsigned CON_DIR      = 13;
    localparam int unsigned CON_HALF     = 12;
    localparam int unsigned CON_NULL_WRITE_MODE    = 11;
    localparam int unsigned CON_AM_LO    = 4;
    localparam int unsigned CON_MD_LO    = 0;
    localparam logic [15:0] CON_MASK     = 16'hf833;
    localparam int unsigned REQ_FORCE    = 15;
    localparam logic [15:0] REQ_MASK     = 16'h00ff;
    localparam logic [15:0] STAH_MASK    = 16'h00ff;
    localparam logic [13:0] CNT_MASK     = 14'h3fff;
    localparam logic [15:0] RESET_VAL    = 16'h0000;
    // Addressing modes
    localparam logic [1:0] AM_POSTINC    = 2'h0;
    localparam logic [1:0] AM_NOINC      = 2'h1;
    localparam logic [1:0] AM_PERIPH     = 2'h2;
    // Operating modes: bit0 = ping-pong, bit1 = one-shot
    localparam int unsigned MD_PP        = 0;
    localparam int unsigned MD_ONESHOT   = 1;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
    typedef enum logic [1:0] {DCC_IDLE, DCC_MEM, DCC_PER} dcc_xfer_t;
endpackage

//--- design/dcc_top.sv
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ns
module dcc_top
    import dcc_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic [255:0]        irq_src,
    output logic                     bus_req,
    output logic                     bus_we,
    output logic                     bus_byte,
    output logic [31:0]              bus_addr,
    output logic [15:0]              bus_wdata,
    input  wire logic [15:0]         bus_rdata,
    input  wire logic                bus_ack,
    input  wire logic [15:0]         periph_ind_addr,
    output logic [NUM_CH-1:0]        channel_irq
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    // per-channel copies
    logic [15:0] con_q   [NUM_CH];
    logic [15:0] req_q   [NUM_CH];
    logic [31:0] sta_q   [NUM_CH];
    logic [31:0] stb_q   [NUM_CH];
    logic [15:0] pad_q   [NUM_CH];
    logic [13:0] cnt_q   [NUM_CH];
    logic [NUM_CH-1:0] pwc_q;
    logic [NUM_CH-1:0] rqc_q;
    logic [1:0]        lca_q;
    logic [31:0]       ladr_q;
    logic [NUM_CH-1:0] pend;
    logic [NUM_CH-1:0] coll;
    logic [NUM_CH-1:0] useb;
    logic [NUM_CH-1:0] fdone;
    logic [NUM_CH-1:0] cfgw;
    logic [31:0]       maddr [NUM_CH];
    dcc_xfer_t         st_q;
    logic [1:0]        gnt_ch;
    logic [NUM_CH-1:0] done_v;
    logic              null_q;

    // AXI write and read side
    logic              aw_q;
    logic              w_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;
    logic              wr_go;
    logic [15:0]       wv;
    logic [1:0]        wch;
    logic [4:0]        woff;
    logic              wmap;

    assign s_axi_awready = ~aw_q & ~bvalid_q;
    assign s_axi_wready  = ~w_q & ~bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign wr_go = aw_q & w_q & ~bvalid_q;
    assign wv    = {wstrb_q[1] ? wdata_q[15:8] : 8'h00, wstrb_q[0] ? wdata_q[7:0] : 8'h00};
    assign wch   = awaddr_q[6:5];
    assign woff  = awaddr_q[4:0];
    assign wmap  = ~awaddr_q[7] & (awaddr_q[1:0] == 2'h0);

    // ------------------------------------------------------------
    // AXI handshake
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            awaddr_q <= '0;
            wdata_q  <= 32'h0;
            wstrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q     <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= (wmap || awaddr_q <= OFF_LADRL) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Channel registers
    // ------------------------------------------------------------
    // Full writes only on the low half; upper lanes are unimplemented
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gch
            logic wsel;
            assign wsel    = wr_go & wmap & (wch == 2'(g));
            assign cfgw[g] = wsel & (woff == OFF_CON);
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    con_q[g] <= RESET_VAL;
                    sta_q[g] <= 32'h0;
                    stb_q[g] <= 32'h0;
                    pad_q[g] <= RESET_VAL;
                    cnt_q[g] <= 14'h0;
                end else if (wsel) begin
                    case (woff)
                        OFF_CON:  con_q[g] <= wv & CON_MASK;
                        OFF_STAH: sta_q[g][31:16] <= wv & STAH_MASK;
                        OFF_STAL: sta_q[g][15:0]  <= wv;
                        OFF_STBH: stb_q[g][31:16] <= wv & STAH_MASK;
                        OFF_STBL: stb_q[g][15:0]  <= wv;
                        OFF_PAD:  pad_q[g] <= wv;
                        OFF_CNT:  cnt_q[g] <= wv[13:0] & CNT_MASK;
                        default: ;
                    endcase
                end
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    req_q[g] <= RESET_VAL;
                end else begin
                    if (wsel && woff == OFF_REQ) begin
                        req_q[g][7:0] <= wv[7:0];
                        if (wv[REQ_FORCE]) begin
                            req_q[g][REQ_FORCE] <= 1'b1;
                        end
                    end
                    if (fdone[g] || !con_q[g][CON_ON]) begin
                        req_q[g][REQ_FORCE] <= 1'b0;
                    end
                end
            end
            // Channel interrupts leave as pulses for the external flag register
            // flag kept outside; also outside
            dcc_channel u_ch (
                .clk        (clk),
                .rst_n      (rst_n),
                .con        (con_q[g]),
                .trig_sel   (req_q[g][7:0]),
                .sta_a      (sta_q[g]),
                .sta_b      (stb_q[g]),
                .count      (cnt_q[g]),
                .cfg_wr     (cfgw[g]),
                .force_req  (req_q[g][REQ_FORCE]),
                .irq_src    (irq_src),
                .grant      (gnt_ch == 2'(g) && st_q != DCC_IDLE),
                .done       (done_v[g]),
                .pending    (pend[g]),
                .mem_addr   (maddr[g]),
                .collide    (coll[g]),
                .use_b      (useb[g]),
                .force_done (fdone[g]),
                .irq_pulse  (channel_irq[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Arbiter and transfer engine
    // ------------------------------------------------------------
    logic [15:0] data_q;
    logic        dir;
    logic        null_write_mode;
    logic [15:0] paddr;

    assign dir   = con_q[gnt_ch][CON_DIR];
    assign null_write_mode = con_q[gnt_ch][CON_NULL_WRITE_MODE] & ~dir;
    assign paddr = (con_q[gnt_ch][CON_AM_LO +: 2] == AM_PERIPH) ? periph_ind_addr
                                                                : pad_q[gnt_ch];

    always_comb begin
        done_v = '0;
        if (st_q == DCC_PER && bus_ack && (!null_write_mode || null_q)) begin
            done_v[gnt_ch] = 1'b1;
        end
    end

    // Read phase then write phase; source side first by direction
    always_comb begin
        bus_req   = (st_q != DCC_IDLE);
        bus_byte  = con_q[gnt_ch][CON_SIZE];
        bus_addr  = 32'h0;
        bus_we    = 1'b0;
        bus_wdata = data_q;
        case (st_q)
            DCC_MEM: begin
                bus_addr = dir ? maddr[gnt_ch] : {16'h0, paddr};
                bus_we   = 1'b0;
            end
            DCC_PER: begin
                bus_addr  = dir ? {16'h0, paddr} : maddr[gnt_ch];
                bus_we    = 1'b1;
                if (null_q) begin
                    bus_addr  = {16'h0, paddr};
                    bus_wdata = 16'h0;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= DCC_IDLE;
            gnt_ch <= 2'h0;
            data_q <= 16'h0;
        end else begin
            case (st_q)
                DCC_IDLE: begin
                    for (int i = NUM_CH - 1; i >= 0; i--) begin
                        if (pend[i]) begin
                            gnt_ch <= 2'(i);
                            st_q   <= DCC_MEM;
                        end
                    end
                end
                DCC_MEM: if (bus_ack) begin
                    data_q <= bus_rdata;
                    st_q   <= DCC_PER;
                end
                DCC_PER: if (bus_ack && (!null_write_mode || null_q)) begin
                    st_q <= DCC_IDLE;
                end
                default: st_q <= DCC_IDLE;
            endcase
        end
    end

    // null write after the memory write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            null_q <= 1'b0;
        end else if (st_q == DCC_PER && bus_ack) begin
            null_q <= null_write_mode & ~null_q;
        end
    end

    // ------------------------------------------------------------
    // Shared status
    // ------------------------------------------------------------
    // single shared set; collisions; last access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwc_q  <= '0;
            rqc_q  <= '0;
            lca_q  <= 2'h0;
            ladr_q <= 32'h0;
        end else begin
            // Set beats clear: events in the clearing cycle survive
            rqc_q <= ((wr_go && awaddr_q == OFF_RQC) ? rqc_q & ~wv[NUM_CH-1:0] : rqc_q) | coll;
            pwc_q <= ((wr_go && awaddr_q == OFF_PWC) ? pwc_q & ~wv[NUM_CH-1:0] : pwc_q)
                   | (cfgw & pend);
            if (st_q != DCC_IDLE && bus_ack) begin
                lca_q  <= gnt_ch;
                ladr_q <= bus_addr;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= 32'h0;
            if (!s_axi_araddr[7]) begin
                case (s_axi_araddr[4:0])
                    OFF_CON:  rdata_q <= {16'h0, con_q[s_axi_araddr[6:5]]};
                    OFF_REQ:  rdata_q <= {16'h0, req_q[s_axi_araddr[6:5]]};
                    OFF_STAH: rdata_q <= {16'h0, sta_q[s_axi_araddr[6:5]][31:16]};
                    OFF_STAL: rdata_q <= {16'h0, sta_q[s_axi_araddr[6:5]][15:0]};
                    OFF_STBH: rdata_q <= {16'h0, stb_q[s_axi_araddr[6:5]][31:16]};
                    OFF_STBL: rdata_q <= {16'h0, stb_q[s_axi_araddr[6:5]][15:0]};
                    OFF_PAD:  rdata_q <= {16'h0, pad_q[s_axi_araddr[6:5]]};
                    OFF_CNT:  rdata_q <= {18'h0, cnt_q[s_axi_araddr[6:5]]};
                    default:  rresp_q <= RESP_SLVERR;
                endcase
            end else begin
                case (s_axi_araddr)
                    OFF_PWC:   rdata_q <= {28'h0, pwc_q};
                    OFF_RQC:   rdata_q <= {28'h0, rqc_q};
                    OFF_PPS:   rdata_q <= {28'h0, useb};
                    OFF_LCA:   rdata_q <= {30'h0, lca_q};
                    OFF_LADRH: rdata_q <= {16'h0, ladr_q[31:16]};
                    OFF_LADRL: rdata_q <= {16'h0, ladr_q[15:0]};
                    default:   rresp_q <= RESP_SLVERR;
                endcase
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule

//--- testbench/dcc_asserts.sv
`timescale 1ns/1ns
module dcc_asserts (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        bus_req,
    input wire logic        bus_ack,
    input wire logic [3:0]  channel_irq
);
    // ------------------------------------------------------------
    // Bus and event checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_b_stands: assert property (s_b_wait |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data unstable");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
    a_bus_holds: assert property (bus_req && !bus_ack |=> bus_req)
        else $error("bus request dropped");
    a_irq_pulse: assert property (|channel_irq |=> (channel_irq & $past(channel_irq)) == 4'h0)
        else $error("irq longer than a cycle");
endmodule
bind dcc_top dcc_asserts u_chk (.*);

//--- testbench/dcc_mem_model.sv
`timescale 1ns/1ns
module dcc_mem_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic bus_req,
    output logic [15:0] bus_rdata,
    output logic        bus_ack
);
    logic [3:0] cnt_q;
    // ------------------------------------------------------------
    // Answers alternate between prompt and stalled
    // ------------------------------------------------------------
    // Data changes every cycle outside an answer so stale reads show
    assign bus_rdata = bus_ack ? {12'hc3a, cnt_q} : {cnt_q, 12'h5c3};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= 4'h0;
            bus_ack <= 1'b0;
        end else begin
            cnt_q   <= cnt_q + 4'h1;
            bus_ack <= bus_req && !bus_ack && cnt_q[1];
        end
    end
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top
    import dcc_pkg::*;
;
    logic         clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic         s_axi_rvalid, s_axi_rready, bus_req, bus_we, bus_byte, bus_ack;
    logic [7:0]   s_axi_awaddr, s_axi_araddr;
    logic [31:0]  s_axi_wdata, s_axi_rdata, bus_addr, first_a, first_w, d, r, w [32];
    logic [3:0]   s_axi_wstrb, channel_irq;
    logic [1:0]   s_axi_bresp, s_axi_rresp;
    logic [15:0]  bus_wdata, bus_rdata, periph_ind_addr;
    logic [255:0] irq_src;
    logic         seen_a, seen_w;
    int           n_mismatch, comparisons, seed, irq_cnt [4];

    dcc_top uut (.*);
    dcc_mem_model u_mem (.*);
    // ------------------------------------------------------------
    // Clock, helpers and monitor
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic end_of_test;
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ad, wd;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        ad = 1'b0;
        wd = 1'b0;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (!ad && s_axi_awready === 1'b1) begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wd && s_axi_wready === 1'b1) begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge clk);
        s_axi_bready <= 1'b0;
        r = 32'(s_axi_bresp);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = 32'(s_axi_rresp);
    endtask
    function automatic logic [15:0] msk(input int i);
        case (i % 8)
            0: msk = CON_MASK;
            1: msk = REQ_MASK;
            2, 4: msk = STAH_MASK;
            7: msk = {2'b00, CNT_MASK};
            default: msk = 16'hffff;
        endcase
    endfunction
    // Register order: select, start high, start low, peripheral, count, control
    task automatic cfg(input logic [7:0] b, input logic [15:0] q, p, s, c, n);
        wr(b + 8'h04, {16'h0, q});
        wr(b + 8'h08, 32'h0);
        wr(b + 8'h0c, {16'h0, s});
        wr(b + 8'h18, {16'h0, p});
        wr(b + 8'h1c, {16'h0, c});
        wr(b, {16'h0, n});
    endtask
    task automatic pulse(input int k, input int gap);
        @(posedge clk);
        irq_src[k] <= 1'b1;
        @(posedge clk);
        irq_src[k] <= 1'b0;
        repeat (gap) @(posedge clk);
    endtask
    always @(posedge clk) begin
        for (int k = 0; k < 4; k++) if (channel_irq[k] === 1'b1) irq_cnt[k]++;
        if (!seen_a && bus_req === 1'b1) begin
            seen_a  <= 1'b1;
            first_a <= bus_addr;
        end
        if (!seen_w && bus_ack === 1'b1 && bus_we === 1'b1) begin
            seen_w  <= 1'b1;
            first_w <= bus_addr;
        end
    end
    initial begin
        repeat (8000) @(posedge clk);
        n_mismatch++;
        end_of_test;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h3415225f;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0;
        s_axi_wstrb <= 4'hf;
        irq_src <= 256'h0;
        periph_ind_addr <= 16'h0;
        {seen_a, seen_w} = 2'h0;
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // Enable and force stay clear so nothing starts yet
        for (int i = 0; i < 32; i++) begin
            rd(8'(i * 4));
            chk(d, 32'h0);
            w[i] = $random(seed);
            if (i % 8 < 2) w[i][15] = 1'b0;
            wr(8'(i * 4), w[i]);
        end
        for (int i = 0; i < 32; i++) begin
            rd(8'(i * 4));
            chk(d, {16'h0, w[i][15:0] & msk(i)});
        end
        rd(8'h98);
        chk(r, 32'(RESP_SLVERR));
        cfg(8'h20, 16'h5, 16'h0200, 16'h2000, 16'h0, 16'h8002);
        cfg(8'h00, 16'h5, 16'h0100, 16'h1000, 16'h0, 16'h8002);
        cfg(8'h40, 16'h6, 16'h0300, 16'h3000, 16'h3, 16'h9002);
        pulse(5, 80);
        chk({16'h0, first_a[15:0]}, 32'h0100);
        chk(first_w, 32'h1000);
        chk(32'(irq_cnt[0] + irq_cnt[1]), 32'h2);
        pulse(6, 40);
        pulse(6, 40);
        chk(32'(irq_cnt[2]), 32'h1);
        wr(8'h44, 32'h8006);
        repeat (40) @(posedge clk);
        rd(8'h44);
        chk(d, 32'h6);
        rd(8'h8c);
        chk(d, 32'h2);
        rd(8'h94);
        chk(d, 32'h3004);
        // Source held two cycles: the second trigger meets a pending request
        @(posedge clk);
        irq_src[6] <= 1'b1;
        repeat (2) @(posedge clk);
        irq_src[6] <= 1'b0;
        repeat (40) @(posedge clk);
        rd(8'h84);
        chk(d, 32'h4);
        wr(8'h84, 32'h4);
        rd(8'h84);
        chk(d, 32'h0);
        cfg(8'h60, 16'h7, 16'h0400, 16'h4000, 16'h0, 16'hc001);
        pulse(7, 40);
        rd(8'h88);
        chk(d, 32'h8);
        pulse(7, 40);
        rd(8'h90);
        chk(d, {16'h0, w[28][15:0] & msk(28)});
        rd(8'h94);
        chk(d, {16'h0, w[29][15:0]});
        end_of_test;
    end
endmodule
